/* design/mdi_pkg.sv */
/*
 Constants for the direct setpoint input (MDI) command logic:
 register offsets, control bit positions, reset values and scaling.
 Assumes a 32-bit APB with word-aligned registers.
*/
`default_nettype none
package mdi_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_ADAPT     = 8'h04;
	localparam logic [7:0] OFS_TELEGRAM  = 8'h08;
	localparam logic [7:0] OFS_POS       = 8'h0c;
	localparam logic [7:0] OFS_VEL       = 8'h10;
	localparam logic [7:0] OFS_ACC       = 8'h14;
	localparam logic [7:0] OFS_DEC       = 8'h18;
	localparam logic [7:0] OFS_VOVR      = 8'h1c;
	localparam logic [7:0] OFS_STATUS    = 8'h20;
	localparam logic [7:0] OFS_EFF       = 8'h24;
	// Control register bit positions
	localparam int B_MDI    = 0;
	localparam int B_SETUP  = 1;
	localparam int B_ABS    = 2;
	localparam int B_CONT   = 3;
	localparam int B_ACCEPT = 4;
	localparam int B_DPOS   = 5;
	localparam int B_DNEG   = 6;
	localparam int B_STOP_N = 7;
	localparam int B_REJ_N  = 8;
	localparam int B_MODULO = 9;
	localparam int CTRL_W   = 10;
	// Status register bit positions
	localparam int S_HOME   = 11;
	localparam int S_ACK    = 12;
	localparam int S_RUN     = 2;
	localparam int S_REFUSED = 3;
	localparam int S_VALID   = 4;
	// Reset values, free telegram number and override scaling shift
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
	localparam logic [15:0] PCT_100        = 16'h4000;
	localparam logic [31:0] VEL_RST        = 32'h0000_0064;
	localparam logic [15:0] TELEGRAM_FREE  = 16'h03e7;
	localparam int          PCT_SHIFT      = 14;
	// Mode adaptation nibble (bits 7:4) codes
	localparam int         MA_LSB     = 4;
	localparam logic [3:0] MA_ABS     = 4'h0;
	localparam logic [3:0] MA_REL     = 4'h1;
	localparam logic [3:0] MA_ABS_POS = 4'h2;
	localparam logic [3:0] MA_ABS_NEG = 4'h3;
endpackage
`default_nettype wire

/* design/mdi_setpoint_command_logic.sv */
/*
 Command logic for direct setpoint input mode of a positioning drive:
 mode select, setpoint take-over, acknowledge, direction decode, overrides.
 Assumes all status inputs come from logic on clk; registers reached over APB.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Reversal needed: keep larger deceleration override
// - Override 16'h4000 means exactly 100 percent
// - Velocity override acts in listed modes only
// - Velocity override defaults to 100 percent
// - Report effective override, limited separately
// - Mode-select bit, default 0, enables MDI
// - Setup select switches on the fly
// - Relative moves allowed without home set
// - Positioning type 1 absolute, 0 relative
// - Absolute move refused unless home set
// - Positioning type read only when adaptation zero
// - Transfer type: continuous or on accept edge
// - Continuous transfer starts motion without command
// - Transfer type writable only at telegram 999
// - Accept rising edge latches all values except velocity override
// - Acknowledge accept with rising status bit 12
// - Stop and reject override accepted command
// - Setup: one direction moves, else zero speed
// - Modulo absolute: direction pair or shortest path
// - Intermediate stop low brakes with parameter decel
// - Reject low aborts task, brakes at maximum
// - Setup select 1 setup, 0 positioning
// - Nonzero adaptation ignores type and directions
module mdi_setpoint_command_logic
	import mdi_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic        home_set_status,
	input  wire logic        blocks_active,
	input  wire logic        jog_active,
	input  wire logic        homing_active,
	input  wire logic        cam_approach,
	input  wire logic [15:0] vel_limit_override,
	input  wire logic        reversal_needed,
	output logic             mdi_active,
	output logic             setup_active,
	output logic             motion_run,
	output logic             dir_positive,
	output logic             dir_negative,
	output logic             shortest_path,
	output logic             brake_param,
	output logic             brake_max,
	output logic             abs_refused,
	output logic             accept_ack_status,
	output logic [31:0]      target_pos,
	output logic [31:0]      target_vel,
	output logic [15:0]      accel_override,
	output logic [15:0]      decel_override,
	output logic [15:0]      effective_override
);

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [15:0]       adapt;
		logic [15:0]       telegram;
		logic [31:0]       pos_in;
		logic [31:0]       vel_in;
		logic [15:0]       acc_in;
		logic [15:0]       dec_in;
		logic [15:0]       vovr_in;
		logic              accept_prev;
		logic              ack;
		logic              cmd_valid;
		logic              act_abs;
		logic              act_dpos;
		logic              act_dneg;
		logic [31:0]       act_pos;
		logic [31:0]       act_vel;
		logic [15:0]       act_acc;
		logic [15:0]       act_dec;
		logic [15:0]       eff;
		logic [31:0]       vel_out;
		logic [31:0]       rdata;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// Larger of two percentages
	function automatic logic [15:0] pct_max(input logic [15:0] a, input logic [15:0] b);
		pct_max = (a > b) ? a : b;
	endfunction

	// Word-aligned register match
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	logic        wr_en;
	logic        rd_en;
	logic        mapped;
	logic        edge_seen;
	logic        take;
	logic        ma_zero;
	logic [3:0]  ma_code;
	logic        sel_abs;
	logic        sel_dpos;
	logic        sel_dneg;
	logic        ovr_scope;
	logic [15:0] req_ovr;
	logic [15:0] eff_c;
	logic [47:0] vel_prod;
	logic        dir_one;
	logic        run_c;
	logic        refuse_c;
	logic [31:0] status_w;

	// Bus decode, answer with no wait state
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !penable && !pwrite;
	assign mapped  = hit(paddr, OFS_CTRL) || hit(paddr, OFS_ADAPT) || hit(paddr, OFS_TELEGRAM)
		|| hit(paddr, OFS_POS) || hit(paddr, OFS_VEL) || hit(paddr, OFS_ACC) || hit(paddr, OFS_DEC)
		|| hit(paddr, OFS_VOVR) || hit(paddr, OFS_STATUS) || hit(paddr, OFS_EFF);
	assign pready  = psel && penable;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = state_reg.rdata;

	// Mode adaptation decode and type/direction selection
	assign ma_zero  = (state_reg.adapt == 16'h0000);
	assign ma_code  = state_reg.adapt[MA_LSB +: 4];
	assign sel_abs  = ma_zero ? state_reg.ctrl[B_ABS] : (ma_code != MA_REL);
	assign sel_dpos = ma_zero ? state_reg.ctrl[B_DPOS] : (ma_code == MA_ABS_POS);
	assign sel_dneg = ma_zero ? state_reg.ctrl[B_DNEG] : (ma_code == MA_ABS_NEG);

	// Acceptance edge and take-over moment
	assign edge_seen = state_reg.ctrl[B_ACCEPT] && !state_reg.accept_prev;
	assign take      = state_reg.ctrl[B_MDI]
		&& (state_reg.ctrl[B_CONT] || edge_seen);

	// Override scope, default and limit
	assign ovr_scope = state_reg.ctrl[B_MDI] || blocks_active || jog_active
		|| (homing_active && cam_approach);
	assign req_ovr   = ovr_scope ? state_reg.vovr_in : PCT_100;
	assign eff_c     = (req_ovr > vel_limit_override) ? vel_limit_override : req_ovr;
	assign vel_prod  = state_reg.act_vel * state_reg.eff;

	// Motion qualification
	assign dir_one   = state_reg.act_dpos ^ state_reg.act_dneg;
	assign refuse_c  = !state_reg.ctrl[B_SETUP] && state_reg.act_abs && !home_set_status;
	assign run_c     = state_reg.ctrl[B_MDI] && state_reg.cmd_valid
		&& state_reg.ctrl[B_STOP_N] && state_reg.ctrl[B_REJ_N] && !refuse_c
		&& (!state_reg.ctrl[B_SETUP] || dir_one);

	// Status word seen by software
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[B_MDI] = state_reg.ctrl[B_MDI];
		status_w[B_SETUP] = state_reg.ctrl[B_MDI] && state_reg.ctrl[B_SETUP];
		status_w[S_RUN] = run_c;
		status_w[S_REFUSED] = refuse_c;
		status_w[S_VALID] = state_reg.cmd_valid;
		status_w[S_HOME] = home_set_status;
		status_w[S_ACK] = state_reg.ack;
	end

	// Next-state logic
	always_comb begin
		state_next = state_reg;
		state_next.accept_prev = state_reg.ctrl[B_ACCEPT];
		// Register writes
		if (wr_en) begin
			case (paddr)
				OFS_CTRL: begin
					state_next.ctrl = pwdata[CTRL_W-1:0];
					if (state_reg.telegram != TELEGRAM_FREE) begin
						state_next.ctrl[B_CONT] = state_reg.ctrl[B_CONT];
					end
				end
				OFS_ADAPT:    state_next.adapt = pwdata[15:0];
				OFS_TELEGRAM: state_next.telegram = pwdata[15:0];
				OFS_POS:      state_next.pos_in = pwdata;
				OFS_VEL:      state_next.vel_in = pwdata;
				OFS_ACC:      state_next.acc_in = pwdata[15:0];
				OFS_DEC:      state_next.dec_in = pwdata[15:0];
				OFS_VOVR:     state_next.vovr_in = pwdata[15:0];
				default: begin
					state_next.adapt = state_reg.adapt;
				end
			endcase
		end
		// Read data captured in the setup phase
		if (rd_en) begin
			case (paddr)
				OFS_CTRL:     state_next.rdata = {{(32-CTRL_W){1'b0}}, state_reg.ctrl};
				OFS_ADAPT:    state_next.rdata = {16'h0000, state_reg.adapt};
				OFS_TELEGRAM: state_next.rdata = {16'h0000, state_reg.telegram};
				OFS_POS:      state_next.rdata = state_reg.pos_in;
				OFS_VEL:      state_next.rdata = state_reg.vel_in;
				OFS_ACC:      state_next.rdata = {16'h0000, state_reg.acc_in};
				OFS_DEC:      state_next.rdata = {16'h0000, state_reg.dec_in};
				OFS_VOVR:     state_next.rdata = {16'h0000, state_reg.vovr_in};
				OFS_STATUS:   state_next.rdata = status_w;
				OFS_EFF:      state_next.rdata = {16'h0000, state_reg.eff};
				default:      state_next.rdata = 32'h0000_0000;
			endcase
		end
		// Take over setpoints, accel/decel overrides, type and directions
		if (take) begin
			state_next.act_pos   = state_reg.pos_in;
			state_next.act_vel   = state_reg.vel_in;
			state_next.act_acc   = state_reg.acc_in;
			state_next.act_dec   = reversal_needed
				? pct_max(state_reg.dec_in, state_reg.act_dec) : state_reg.dec_in;
			state_next.act_abs   = sel_abs;
			state_next.act_dpos  = sel_dpos;
			state_next.act_dneg  = sel_dneg;
			state_next.cmd_valid = 1'b1;
		end
		// Acknowledge: set on edge, hold until accept falls
		if (state_reg.ctrl[B_MDI] && !state_reg.ctrl[B_CONT] && edge_seen) begin
			state_next.ack = 1'b1;
		end else if (!state_reg.ctrl[B_ACCEPT]) begin
			state_next.ack = 1'b0;
		end
		// Reject or leaving the mode drops the task
		if (!state_reg.ctrl[B_REJ_N] || !state_reg.ctrl[B_MDI]) begin
			state_next.cmd_valid = 1'b0;
		end
		state_next.eff     = eff_c;
		state_next.vel_out = vel_prod[PCT_SHIFT +: 32];
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg          <= '0;
			state_reg.ctrl     <= CTRL_RST;
			state_reg.vel_in   <= VEL_RST;
			state_reg.acc_in   <= PCT_100;
			state_reg.dec_in   <= PCT_100;
			state_reg.vovr_in  <= PCT_100;
			state_reg.act_acc  <= PCT_100;
			state_reg.act_dec  <= PCT_100;
			state_reg.eff      <= PCT_100;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs to the profile generator
	assign mdi_active         = state_reg.ctrl[B_MDI];
	assign setup_active       = state_reg.ctrl[B_MDI] && state_reg.ctrl[B_SETUP];
	assign motion_run         = run_c;
	assign dir_positive       = state_reg.ctrl[B_SETUP]
		? (state_reg.act_dpos && !state_reg.act_dneg)
		: (state_reg.act_abs && state_reg.ctrl[B_MODULO]
			&& state_reg.act_dpos && !state_reg.act_dneg);
	assign dir_negative       = state_reg.ctrl[B_SETUP]
		? (state_reg.act_dneg && !state_reg.act_dpos)
		: (state_reg.act_abs && state_reg.ctrl[B_MODULO]
			&& state_reg.act_dneg && !state_reg.act_dpos);
	assign shortest_path      = !state_reg.ctrl[B_SETUP] && state_reg.act_abs
		&& state_reg.ctrl[B_MODULO] && !dir_one;
	assign brake_param        = state_reg.ctrl[B_MDI] && !state_reg.ctrl[B_STOP_N]
		&& state_reg.ctrl[B_REJ_N];
	assign brake_max          = state_reg.ctrl[B_MDI] && !state_reg.ctrl[B_REJ_N];
	assign abs_refused        = state_reg.ctrl[B_MDI] && state_reg.cmd_valid && refuse_c;
	assign accept_ack_status  = state_reg.ack;
	assign target_pos         = state_reg.act_pos;
	assign target_vel         = state_reg.vel_out;
	assign accel_override     = state_reg.act_acc;
	assign decel_override     = state_reg.act_dec;
	assign effective_override = state_reg.eff;

	// Checks
	property p_ack_rise;
		@(posedge clk) disable iff (rst)
		(state_reg.ctrl[B_MDI] && !state_reg.ctrl[B_CONT] && edge_seen) |=> accept_ack_status;
	endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("ack missing after accept edge");

	property p_ack_hold;
		@(posedge clk) disable iff (rst)
		(accept_ack_status && state_reg.ctrl[B_ACCEPT]) |=> accept_ack_status;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack dropped while accept high");

	property p_edge_latch;
		@(posedge clk) disable iff (rst)
		(take && !$past(take)) |=> (target_pos == $past(state_reg.pos_in));
	endproperty
	a_edge_latch: assert property (p_edge_latch) else $error("setpoint not taken over");

	property p_no_take_static;
		@(posedge clk) disable iff (rst)
		(!state_reg.ctrl[B_CONT] && !edge_seen && !wr_en) ##1 !edge_seen |-> $stable(target_pos);
	endproperty
	a_no_take_static: assert property (p_no_take_static) else $error("setpoint moved without edge");

	property p_abs_refuse;
		@(posedge clk) disable iff (rst)
		(motion_run && !state_reg.ctrl[B_SETUP] && state_reg.act_abs) |-> home_set_status;
	endproperty
	a_abs_refuse: assert property (p_abs_refuse) else $error("absolute move without home");

	property p_setup_zero;
		@(posedge clk) disable iff (rst)
		(setup_active && (state_reg.act_dpos == state_reg.act_dneg)) |-> !motion_run;
	endproperty
	a_setup_zero: assert property (p_setup_zero) else $error("setup moves without one direction");

	property p_stop_halts;
		@(posedge clk) disable iff (rst)
		(!state_reg.ctrl[B_STOP_N] || !state_reg.ctrl[B_REJ_N]) |-> !motion_run;
	endproperty
	a_stop_halts: assert property (p_stop_halts) else $error("motion despite stop or reject");

	property p_eff_limit;
		@(posedge clk) disable iff (rst)
		##1 (effective_override <= $past(vel_limit_override));
	endproperty
	a_eff_limit: assert property (p_eff_limit) else $error("override above limit");

	property p_telegram_lock;
		@(posedge clk) disable iff (rst)
		(state_reg.telegram != TELEGRAM_FREE) |=> (state_reg.ctrl[B_CONT] == $past(state_reg.ctrl[B_CONT]));
	endproperty
	a_telegram_lock: assert property (p_telegram_lock) else $error("transfer type changed while locked");

	property p_shortest;
		@(posedge clk) disable iff (rst)
		shortest_path |-> (!dir_positive && !dir_negative);
	endproperty
	a_shortest: assert property (p_shortest) else $error("shortest path with direction");

	property p_mode_off;
		@(posedge clk) disable iff (rst)
		!mdi_active |-> (!motion_run && !setup_active);
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("motion or setup without mode select");

	property p_reject_drops;
		@(posedge clk) disable iff (rst)
		!state_reg.ctrl[B_REJ_N] |=> !state_reg.cmd_valid;
	endproperty
	a_reject_drops: assert property (p_reject_drops) else $error("task kept after reject");

	property p_ovr_default;
		@(posedge clk) disable iff (rst)
		(!ovr_scope && (vel_limit_override >= PCT_100)) |=> (effective_override == PCT_100);
	endproperty
	a_ovr_default: assert property (p_ovr_default) else $error("override not at full scale");

	property p_adapt_ignore;
		@(posedge clk) disable iff (rst)
		(take && !ma_zero && (ma_code == MA_REL)) |=> !state_reg.act_abs;
	endproperty
	a_adapt_ignore: assert property (p_adapt_ignore) else $error("type input used under adaptation");

	property p_cont_take;
		@(posedge clk) disable iff (rst)
		(mdi_active && state_reg.ctrl[B_CONT]) |=> (target_pos == $past(state_reg.pos_in));
	endproperty
	a_cont_take: assert property (p_cont_take) else $error("continuous take-over missed");

endmodule
`default_nettype wire

/* testbench/mdi_controller_model.sv */
/*
 Motion controller model: APB master that issues MDI commands.
 Assumes the command logic shares clk and answers with pready.
*/
`timescale 1ns/1ps
`default_nettype none
module mdi_controller_model
	import mdi_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	input  wire logic        accept_ack_status,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	int tmo = 0; // Waits that ran out
	logic err = 1'b0; // Error flag of the last access

	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// One transfer; released address and data flip so stale values never pass
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) tmo++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask

	// Accept edge: raise, wait for acknowledge, then drop before any next edge
	task automatic accept(input logic [31:0] c);
		logic [31:0] q;
		int n;
		xfer(1'b1, OFS_CTRL, c | 32'h10, q);
		n = 0;
		while (accept_ack_status !== 1'b1 && n < 16) begin
			@(posedge clk);
			n++;
		end
		if (n >= 16) tmo++;
		xfer(1'b1, OFS_CTRL, c & ~32'h10, q);
	endtask
endmodule
`default_nettype wire

/* testbench/test_mdi_setpoint_command_logic.sv */
/*
 Self-checking bench for the MDI command logic: direction table, take-over,
 refusal, braking, overrides and reset. Assumes the controller model drives APB.
*/
`timescale 1ns/1ps
`default_nettype none
module test_mdi_setpoint_command_logic
	import mdi_pkg::*;
();
	typedef struct packed {logic [31:0] c; logic [15:0] ad; logic [4:0] e; logic [4:0] m;} row_t;
	logic        clk = 1'b0, rst = 1'b1, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, target_pos, target_vel, q;
	logic        home_set_status = 1'b0, blocks_active = 1'b0, jog_active = 1'b0;
	logic        homing_active = 1'b0, cam_approach = 1'b0, reversal_needed = 1'b0;
	logic [15:0] vel_limit_override = 16'hffff, accel_override, decel_override, effective_override;
	logic        mdi_active, setup_active, motion_run, dir_positive, dir_negative, shortest_path;
	logic        brake_param, brake_max, abs_refused, accept_ack_status;
	int          fail_count = 0, cmp_count = 0;
	// Rows: control word, adaptation, expected {mdi,setup,pos,neg,shortest}, mask
	row_t rows [12] = '{
		'{32'h18b, 16'h0, 5'b11000, 5'b11110}, '{32'h1ab, 16'h0, 5'b11100, 5'b11110},
		'{32'h1cb, 16'h0, 5'b11010, 5'b11110}, '{32'h1eb, 16'h0, 5'b11000, 5'b11110},
		'{32'h38d, 16'h0, 5'b10001, 5'b11111}, '{32'h3ad, 16'h0, 5'b10100, 5'b11111},
		'{32'h3cd, 16'h0, 5'b10010, 5'b11111}, '{32'h3ed, 16'h0, 5'b10001, 5'b11111},
		'{32'h3cd, 16'h10, 5'b10000, 5'b11111}, '{32'h3cd, 16'h20, 5'b10100, 5'b11111},
		'{32'h3ad, 16'h30, 5'b10010, 5'b11111}, '{32'h3c9, 16'h100, 5'b10001, 5'b11111}};

	mdi_setpoint_command_logic dut (.*);
	mdi_controller_model ctl (.*);

	// Clock
	always #12.5 clk = ~clk;

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		ctl.xfer(1'b1, a, d, q);
	endtask
	task results;
		fail_count += ctl.tmo;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		home_set_status <= 1'b1;
		wr(OFS_TELEGRAM, 32'h3e7);
		for (int i = 0; i < 12; i++) begin
			wr(OFS_ADAPT, {16'h0, rows[i].ad});
			wr(OFS_CTRL, rows[i].c);
			repeat (2) @(posedge clk);
			chk("dir", 32'(rows[i].e & rows[i].m), 32'({mdi_active, setup_active, dir_positive,
				dir_negative, shortest_path} & rows[i].m));
		end
		wr(OFS_ADAPT, 32'h0);
		$display("test direction table done");
		// Continuous take-over and velocity override
		wr(OFS_CTRL, 32'h189);
		wr(OFS_VOVR, 32'h2000);
		repeat (3) @(posedge clk);
		chk("run", 32'h1, 32'(motion_run));
		chk("eff", 32'h2000, 32'(effective_override));
		chk("tvel", 32'h32, target_vel);
		vel_limit_override <= 16'h1000;
		repeat (3) @(posedge clk);
		chk("eff", 32'h1000, 32'(effective_override));
		vel_limit_override <= 16'hffff;
		wr(OFS_CTRL, 32'h008);
		repeat (3) @(posedge clk);
		chk("eff", 32'h4000, 32'(effective_override));
		jog_active <= 1'b1;
		repeat (3) @(posedge clk);
		chk("eff", 32'h2000, 32'(effective_override));
		jog_active <= 1'b0;
		homing_active <= 1'b1;
		repeat (3) @(posedge clk);
		chk("eff", 32'h4000, 32'(effective_override));
		cam_approach <= 1'b1;
		repeat (3) @(posedge clk);
		chk("eff", 32'h2000, 32'(effective_override));
		homing_active <= 1'b0;
		$display("test override done");
		// Edge take-over, home dependence, braking
		wr(OFS_CTRL, 32'h181);
		wr(OFS_POS, 32'h1234_5678);
		wr(OFS_ACC, 32'h3000);
		home_set_status <= 1'b0;
		repeat (2) @(posedge clk);
		chk("pos", 32'h0, target_pos);
		ctl.accept(32'h181);
		chk("pos", 32'h1234_5678, target_pos);
		chk("acc", 32'h3000, 32'(accel_override));
		chk("run", 32'h2, {motion_run, abs_refused});
		repeat (2) @(posedge clk);
		chk("ack", 32'h0, 32'(accept_ack_status));
		ctl.accept(32'h185);
		chk("refuse", 32'h1, {motion_run, abs_refused});
		home_set_status <= 1'b1;
		repeat (2) @(posedge clk);
		chk("refuse", 32'h2, {motion_run, abs_refused});
		ctl.xfer(1'b0, OFS_STATUS, 32'h0, q);
		chk("status", 32'h815, q);
		wr(OFS_CTRL, 32'h105);
		@(posedge clk);
		chk("brake", 32'h2, {brake_param, brake_max});
		wr(OFS_CTRL, 32'h085);
		@(posedge clk);
		chk("brake", 32'h1, 32'(brake_max));
		$display("test edge take-over done");
		// Deceleration kept when reversal would be needed
		wr(OFS_DEC, 32'h6000);
		ctl.accept(32'h185);
		wr(OFS_DEC, 32'h2000);
		reversal_needed <= 1'b1;
		ctl.accept(32'h185);
		chk("dec", 32'h6000, 32'(decel_override));
		reversal_needed <= 1'b0;
		ctl.accept(32'h185);
		chk("dec", 32'h2000, 32'(decel_override));
		// Transfer type locked outside telegram 999; unmapped read
		wr(OFS_TELEGRAM, 32'h0);
		wr(OFS_CTRL, 32'h18d);
		ctl.xfer(1'b0, OFS_CTRL, 32'h0, q);
		chk("ctrl", 32'h185, q & 32'h3ff);
		chk("slverr", 32'h0, 32'(ctl.err));
		ctl.xfer(1'b0, 8'h3c, 32'h0, q);
		chk("unmapped", 32'h0, q);
		chk("slverr", 32'h1, 32'(ctl.err));
		$display("test decel and lock done");
		// Reset in mid-run
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("mdi", 32'h0, {mdi_active, accept_ack_status});
		chk("ovr", 32'h4000_4000, {decel_override, effective_override});
		ctl.xfer(1'b0, OFS_VOVR, 32'h0, q);
		chk("vovr", 32'h4000, q);
		ctl.xfer(1'b0, OFS_CTRL, 32'h0, q);
		chk("ctrl", 32'h0, q);
		$display("test reset done");
		results();
	end
endmodule
`default_nettype wire
